// [rtl/ufn_port.sv]
// Serial port core: registers, transmitter with flow gate and driver enable, receiver.
// Assumes strobe register port and cts_n/rxd synchronous to clk.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// [RULE1] Flow gate only when enable bit set
// [RULE2] Sample clear-to-send before each new character
// [RULE3] Remote deasserts clear-to-send before character start
// [RULE4] Character in flight always completes
// [RULE5] Ninth bit sits after data, before stop
// [RULE6] Nine-bit mode bit enables multiprocessor mode
// [RULE7] Ninth bit value sent in nine-bit mode
// [RULE8] Filter 00 all bytes, 01 addresses
// [RULE9] Filter 10 matching address plus data
// [RULE10] Filter 11 matched data only
// [RULE11] Frame start flag on first data
// [RULE12] Drive signal covers whole frame
// [RULE13] Drive signal asserts on transmit write
// [RULE14] Drive leads start by one-two bits
// [RULE15] Drive releases one clock after stop
// [RULE16] Drive held across back-to-back characters
// [RULE17] Polarity bit selects drive active level
// [RULE18] Stop-count bit selects one or two
// [RULE19] Loopback routes transmit into receiver
// [RULE20] Software avoids parity in nine-bit mode
// [RULE21] Receive request per error, break, data
// [RULE22] Control register resets zero, fully RW
// [RULE23] Drive inactive when nothing pending
module ufn_port
  import ufn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic cts_n,
  input wire logic rxd,
  output logic txd,
  output logic transceiver_drive_signal,
  output logic rx_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [7:0] addr_cmp_r;
  logic [15:0] baud_r;
  logic [7:0] tx_hold_r;
  logic tx_full_r;
  logic [7:0] rx_data_r;
  logic rda_r, pe_r, oe_r, fe_r, brk_r, frame_start_flag_r;
  logic [7:0] rdata_r;
  logic nine_bit_mode_on;
  logic [1:0] addr_filter_select;
  logic tx_wr;
  logic rx_rd;
  logic st_rd;
  assign nine_bit_mode_on = ctl1_r[C1_NINE_BIT_MODE_ON]; // [RULE6]
  assign addr_filter_select = {ctl1_r[C1_MPMD1], ctl1_r[C1_MPMD0]};
  assign tx_wr = wr && (addr == TXD_OFS);
  assign rx_rd = rd && (addr == RXD_OFS);
  assign st_rd = rd && (addr == STAT_OFS);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl0_r <= CTL_RST;
      ctl1_r <= CTL_RST; // [RULE22]
      addr_cmp_r <= CTL_RST;
      baud_r <= BAUD_RST;
    end
    else if (wr)
    begin
      if (addr == CTL0_OFS)
        ctl0_r <= wdata;
      if (addr == CTL1_OFS)
        ctl1_r <= wdata; // [RULE22]
      if (addr == ADDR_OFS)
        addr_cmp_r <= wdata;
      if (addr == BAUD_OFS)
        baud_r <= {8'h00, wdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ufn_tx_state_t tx_st_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic ninth_r;
  logic stop2_r;
  logic par_r;
  logic tick;
  logic timer_run;
  logic cts_ok;
  logic take;
  logic de_act;
  logic tx_line_r;

  assign timer_run = (tx_st_r != UFN_TX_IDLE) && (tx_st_r != UFN_TX_TAIL);
  ufn_bit_timer u_timer (
    .clk(clk),
    .reset(reset),
    .run(timer_run),
    .divisor(baud_r),
    .tick(tick)
  );

  // Flow gate only applies with enable set; cts_n is sampled the clock before the lead, or before the start when back-to-back
  assign cts_ok = !ctl0_r[C0_FLOW] || !cts_n; // [RULE1] [RULE2]
  assign take = tx_full_r && ctl0_r[C0_TX_ON] && cts_ok;

  always_ff @(posedge clk)
  begin
    if (reset)
      tx_full_r <= 1'b0;
    else if (tx_wr)
      tx_full_r <= 1'b1;
    else if ((tx_st_r == UFN_TX_IDLE || tx_st_r == UFN_TX_TAIL) && take)
      tx_full_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      tx_hold_r <= 8'h00;
    else if (tx_wr)
      tx_hold_r <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_st_r <= UFN_TX_IDLE;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      ninth_r <= 1'b0;
      stop2_r <= 1'b0;
      par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end
    else
    begin
      case (tx_st_r)
        UFN_TX_IDLE, UFN_TX_TAIL:
        begin
          tx_line_r <= 1'b1;
          if (take)
          begin
            sh_r <= tx_hold_r;
            ninth_r <= ctl1_r[C1_NINTH_BIT_VALUE]; // [RULE7]
            par_r <= ^tx_hold_r ^ ctl0_r[C0_PAR_ODD];
            stop2_r <= ctl0_r[C0_STOP2]; // [RULE18]
            // Back-to-back skips the lead since the drive is already on
            tx_st_r <= (tx_st_r == UFN_TX_TAIL) ? UFN_TX_START : UFN_TX_LEAD; // [RULE16]
            tx_line_r <= (tx_st_r == UFN_TX_TAIL) ? 1'b0 : 1'b1;
          end
          else
            tx_st_r <= UFN_TX_IDLE;
        end
        UFN_TX_LEAD:
          if (tick)
          begin
            tx_st_r <= UFN_TX_START; // [RULE14]
            tx_line_r <= 1'b0;
          end
        UFN_TX_START:
          if (tick)
          begin
            tx_st_r <= UFN_TX_DATA;
            bit_r <= 3'h0;
            tx_line_r <= sh_r[0];
          end
        UFN_TX_DATA:
          if (tick)
          begin
            // Once shifting, cts_n is not looked at until the next start
            if (bit_r == 3'h7)
            begin
              if (nine_bit_mode_on || ctl0_r[C0_PAR_ON])
              begin
                tx_st_r <= UFN_TX_NINTH; // [RULE5] [RULE4]
                tx_line_r <= nine_bit_mode_on ? ninth_r : par_r;
              end
              else
              begin
                tx_st_r <= UFN_TX_STOP;
                tx_line_r <= 1'b1;
              end
            end
            else
            begin
              bit_r <= bit_r + 3'h1;
              tx_line_r <= sh_r[bit_r + 3'h1];
            end
          end
        UFN_TX_NINTH:
          if (tick)
          begin
            tx_st_r <= UFN_TX_STOP;
            tx_line_r <= 1'b1;
          end
        UFN_TX_STOP:
          if (tick)
          begin
            if (stop2_r)
              stop2_r <= 1'b0;
            else
              tx_st_r <= UFN_TX_TAIL; // [RULE15]
          end
        default:
          tx_st_r <= UFN_TX_IDLE;
      endcase
    end
  end

  // Drive is on from the transmit write through the tail clock after the last stop
  assign de_act = tx_full_r || (tx_st_r != UFN_TX_IDLE); // [RULE12] [RULE13] [RULE23]
  assign transceiver_drive_signal = de_act ^ ctl1_r[C1_DRIVE_SIGNAL_POLARITY]; // [RULE17]
  assign txd = ctl0_r[C0_LOOP] ? 1'b1 : tx_line_r;

  ////////////////////////////////////////////////////////////////////////////
  logic rx_in;
  logic rx_busy_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic char_done;
  logic [7:0] char_byte;
  logic char_ninth;
  logic accept;
  logic frame_start;
  logic rx_extra;
  logic [3:0] rx_last;
  assign rx_in = ctl0_r[C0_LOOP] ? tx_line_r : rxd; // [RULE19]
  assign rx_extra = nine_bit_mode_on || ctl0_r[C0_PAR_ON];
  assign rx_last = rx_extra ? 4'h9 : 4'h8;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end
    else if (!rx_busy_r)
    begin
      if (ctl0_r[C0_RX_ON] && !rx_in)
      begin
        rx_busy_r <= 1'b1;
        rx_cnt_r <= {1'b0, baud_r[15:1]};
        rx_bit_r <= 4'h0;
      end
    end
    else if (rx_cnt_r == 16'h0000)
    begin
      rx_cnt_r <= baud_r - 16'h0001;
      if (rx_bit_r == rx_last + 4'h1)
        rx_busy_r <= 1'b0;
      else
      begin
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r != 4'h0)
          rx_sh_r <= {rx_in, rx_sh_r[8:1]};
      end
    end
    else
      rx_cnt_r <= rx_cnt_r - 16'h0001;
  end

  assign char_done = rx_busy_r && (rx_cnt_r == 16'h0000) && (rx_bit_r == rx_last + 4'h1);
  assign char_byte = rx_extra ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign char_ninth = rx_sh_r[8];

  ufn_rx_filter u_filter (
    .clk(clk),
    .reset(reset),
    .nine_bit_mode_on(nine_bit_mode_on),
    .addr_filter_select(addr_filter_select),
    .addr_cmp(addr_cmp_r),
    .char_done(char_done),
    .char_byte(char_byte),
    .char_ninth(char_ninth),
    .accept(accept),
    .frame_start(frame_start)
  );

  // Sticky receive status; a new event wins over the clearing read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rda_r <= 1'b0;
      pe_r <= 1'b0;
      oe_r <= 1'b0;
      fe_r <= 1'b0;
      brk_r <= 1'b0;
      frame_start_flag_r <= 1'b0;
      rx_data_r <= 8'h00;
    end
    else if (char_done && (accept || !rx_in || (!nine_bit_mode_on && ctl0_r[C0_PAR_ON]
             && (^rx_sh_r[8:0] != ctl0_r[C0_PAR_ODD]))))
    begin
      rda_r <= 1'b1; // [RULE21]
      rx_data_r <= char_byte;
      oe_r <= rda_r && !rx_rd;
      fe_r <= !rx_in;
      brk_r <= !rx_in && (rx_sh_r == 9'h000);
      pe_r <= !nine_bit_mode_on && ctl0_r[C0_PAR_ON]
              && (^rx_sh_r[8:0] != ctl0_r[C0_PAR_ODD]);
      frame_start_flag_r <= frame_start; // [RULE11]
    end
    else if (rx_rd)
    begin
      rda_r <= 1'b0;
      frame_start_flag_r <= 1'b0;
    end
    else if (st_rd)
    begin
      pe_r <= 1'b0;
      oe_r <= 1'b0;
      fe_r <= 1'b0;
      brk_r <= 1'b0;
    end
  end

  assign rx_irq = rda_r || pe_r || oe_r || fe_r || brk_r; // [RULE21]

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_r <= 8'h00;
    else if (rd)
    begin
      case (addr)
        CTL0_OFS: rdata_r <= ctl0_r;
        CTL1_OFS: rdata_r <= ctl1_r;
        ADDR_OFS: rdata_r <= addr_cmp_r;
        BAUD_OFS: rdata_r <= baud_r[7:0];
        RXD_OFS: rdata_r <= rx_data_r;
        STAT_OFS: rdata_r <= {rda_r, pe_r, oe_r, fe_r, brk_r, !tx_full_r,
                              !tx_full_r && tx_st_r == UFN_TX_IDLE, frame_start_flag_r};
        default: rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  property p_drive_idle;
    @(posedge clk) disable iff (reset)
    (tx_st_r == UFN_TX_IDLE && !tx_full_r) |->
      transceiver_drive_signal == ctl1_r[C1_DRIVE_SIGNAL_POLARITY];
  endproperty
  a_drive_idle: assert property (p_drive_idle) else $error("drive not idle"); // [RULE23]
  property p_write_drives;
    @(posedge clk) disable iff (reset)
    tx_wr |=> (transceiver_drive_signal != ctl1_r[C1_DRIVE_SIGNAL_POLARITY]);
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("no drive on write"); // [RULE13]
  property p_flow_hold;
    @(posedge clk) disable iff (reset)
    (tx_st_r == UFN_TX_IDLE && ctl0_r[C0_FLOW] && cts_n) |=> tx_st_r != UFN_TX_LEAD;
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("start while held"); // [RULE2]
  property p_lead;
    @(posedge clk) disable iff (reset)
    (tx_st_r == UFN_TX_LEAD) |-> de_act && tx_line_r;
  endproperty
  a_lead: assert property (p_lead) else $error("lead without drive"); // [RULE14]
  property p_tail;
    @(posedge clk) disable iff (reset)
    (tx_st_r == UFN_TX_TAIL && !take) |=> tx_st_r == UFN_TX_IDLE;
  endproperty
  a_tail: assert property (p_tail) else $error("tail not one clock"); // [RULE15]
  property p_frame_drive;
    @(posedge clk) disable iff (reset)
    (tx_st_r == UFN_TX_START || tx_st_r == UFN_TX_STOP) |-> de_act && (tx_line_r == tx_st_r[2]);
  endproperty
  a_frame_drive: assert property (p_frame_drive) else $error("frame undriven"); // [RULE12]
  property p_ninth;
    @(posedge clk) disable iff (reset)
    (tx_st_r == UFN_TX_DATA && tick && bit_r == 3'h7 && nine_bit_mode_on) |=>
      tx_st_r == UFN_TX_NINTH && tx_line_r == ninth_r;
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit misplaced"); // [RULE5]
  property p_filter11;
    @(posedge clk) disable iff (reset)
    (char_done && nine_bit_mode_on && addr_filter_select == 2'b11 && char_ninth) |-> !accept;
  endproperty
  a_filter11: assert property (p_filter11) else $error("address accepted"); // [RULE10]
endmodule : ufn_port

// [rtl/ufn_pkg.sv]
// Constants for the serial port with flow control, nine-bit addressing and driver enable.
// Assumes one 100 MHz system clock and a simple strobe register port.
package ufn_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam logic [11:0] CTL0_OFS = 12'hF42;
  localparam logic [11:0] CTL1_OFS = 12'hF43;
  localparam logic [11:0] TXD_OFS = 12'hF40;
  localparam logic [11:0] RXD_OFS = 12'hF44;
  localparam logic [11:0] STAT_OFS = 12'hF41;
  localparam logic [11:0] ADDR_OFS = 12'hF45;
  localparam logic [11:0] BAUD_OFS = 12'hF46;
  // Control 0 fields
  localparam int unsigned C0_TX_ON = 7;
  localparam int unsigned C0_RX_ON = 6;
  localparam int unsigned C0_FLOW = 5;
  localparam int unsigned C0_PAR_ON = 4;
  localparam int unsigned C0_PAR_ODD = 3;
  localparam int unsigned C0_STOP2 = 1;
  localparam int unsigned C0_LOOP = 0;
  // Control 1 fields
  localparam int unsigned C1_MPMD1 = 7;
  localparam int unsigned C1_NINE_BIT_MODE_ON = 6;
  localparam int unsigned C1_MPMD0 = 5;
  localparam int unsigned C1_NINTH_BIT_VALUE = 4;
  localparam int unsigned C1_DRIVE_SIGNAL_POLARITY = 3;
  // Status fields
  localparam int unsigned ST_RDA = 7;
  localparam int unsigned ST_PE = 6;
  localparam int unsigned ST_OE = 5;
  localparam int unsigned ST_FE = 4;
  localparam int unsigned ST_BRK = 3;
  localparam int unsigned ST_TDRE = 2;
  localparam int unsigned ST_TXE = 1;
  localparam int unsigned ST_FRAME_START_FLAG = 0;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [3:0] DE_LEAD_BITS = 4'h1;
  typedef enum logic [2:0] {
    UFN_TX_IDLE = 3'b000,
    UFN_TX_LEAD = 3'b001,
    UFN_TX_START = 3'b011,
    UFN_TX_DATA = 3'b010,
    UFN_TX_NINTH = 3'b110,
    UFN_TX_STOP = 3'b111,
    UFN_TX_TAIL = 3'b101
  } ufn_tx_state_t;
endpackage : ufn_pkg

// [rtl/ufn_bit_timer.sv]
// Bit period timer: pulses tick at the end of every bit period while run is high.
// Assumes divisor is at least 1 and is held stable during a character.
`timescale 1ns/1ps
module ufn_bit_timer
  import ufn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk)
  begin
    if (reset || !run)
      cnt_r <= 16'h0000;
    else if (cnt_r + 16'h0001 >= divisor)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end
  assign tick = run && (cnt_r + 16'h0001 >= divisor);
endmodule : ufn_bit_timer

// [rtl/ufn_rx_filter.sv]
// Nine-bit address filter: decides whether a received character raises the receive request.
// Assumes a one-cycle char_done pulse carrying the byte and its ninth bit.
`timescale 1ns/1ps
module ufn_rx_filter
  import ufn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic nine_bit_mode_on,
  input wire logic [1:0] addr_filter_select,
  input wire logic [7:0] addr_cmp,
  input wire logic char_done,
  input wire logic [7:0] char_byte,
  input wire logic char_ninth,
  output logic accept,
  output logic frame_start
);
  logic matched_r;
  logic first_r;
  logic is_addr;
  logic hit;
  assign is_addr = char_ninth;
  assign hit = (char_byte == addr_cmp);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      matched_r <= 1'b0;
      first_r <= 1'b0;
    end
    else if (char_done && nine_bit_mode_on)
    begin
      if (is_addr)
      begin
        matched_r <= hit;
        first_r <= hit;
      end
      else
        first_r <= 1'b0;
    end
  end
  always_comb
  begin
    accept = 1'b0;
    frame_start = 1'b0;
    if (char_done)
    begin
      if (!nine_bit_mode_on)
        accept = 1'b1;
      else
      begin
        case (addr_filter_select)
          2'b00: accept = 1'b1; // [RULE8]
          2'b01: accept = is_addr; // [RULE8]
          2'b10: accept = is_addr ? hit : matched_r; // [RULE9]
          default: accept = !is_addr && matched_r; // [RULE10]
        endcase
        frame_start = !is_addr && matched_r && first_r; // [RULE11]
      end
    end
  end
endmodule : ufn_rx_filter

// [verification/ufn_remote_node.sv]
// Remote serial node: pauses the sender and captures each frame from the line.
// Assumes the line is sampled one step after each rising clock edge.
`timescale 1ns/1ps
module ufn_remote_node #(
  parameter int BIT = 16
)(
  input wire logic clk,
  input wire logic txd,
  input wire logic de_act,
  input wire logic hold_off,
  input wire logic [3:0] nbits,
  output logic cts_n,
  output logic rxd,
  output logic [8:0] frame,
  output int lead,
  output int span,
  output int frames,
  output int drops
);
  int n_drop = 0;
  bit de_q = 1'b0;
  // Bench raises the pause only while idle or mid-character
  assign cts_n = hold_off;
  // Line is pulled high; this node never answers
  assign rxd = 1'b1;
  assign drops = n_drop;
  always @(posedge clk)
  begin
    de_q <= de_act;
    if (de_q && !de_act)
      n_drop <= n_drop + 1;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  initial
  begin
    frames = 0;
    forever
    begin
      while (de_act !== 1'b1)
        step();
      lead = 0;
      frame = '0;
      while (txd !== 1'b0)
      begin
        step();
        lead++;
      end
      // Sample mid-bit so small edge skew does not matter
      repeat (BIT / 2) step();
      for (int i = 0; i < nbits; i++)
      begin
        repeat (BIT) step();
        frame[i] = txd;
      end
      span = BIT / 2 + nbits * BIT;
      // The last bit may be low, so wait out its second half before looking for the end
      while (de_act === 1'b1 && (txd === 1'b1 || span < (1 + nbits) * BIT))
      begin
        step();
        span++;
      end
      frames++;
    end
  end
endmodule : ufn_remote_node

// [verification/ufn_port_tb.sv]
// Self-checking bench for the serial port: registers, flow gate, drive signal, filter.
// Assumes the remote node model beside it and the default 16-clock bit period.
`timescale 1ns/1ps
module ufn_port_tb
  import ufn_pkg::*;
;
  localparam int BIT = 16;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold_off = 1'b0;
  logic drive_signal_polarity_sel = 1'b0;
  logic [3:0] nbits = 4'h8;
  logic [7:0] rdata;
  logic cts_n;
  logic rxd;
  logic txd;
  logic drv;
  logic rx_irq;
  logic [8:0] frame;
  logic [7:0] rv;
  int lead;
  int span;
  int frames;
  int drops;
  int n0;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] rx_byte [4] = '{8'h3C, 8'h11, 8'h55, 8'h22};
  logic [3:0] irq_tab [4] = '{4'hF, 4'h5, 4'h3, 4'h2};
  ufn_port dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cts_n(cts_n), .rxd(rxd), .txd(txd), .transceiver_drive_signal(drv),
    .rx_irq(rx_irq));
  ufn_remote_node #(.BIT(BIT)) node (.clk(clk), .txd(txd), .de_act(drv ^ drive_signal_polarity_sel),
    .hold_off(hold_off), .nbits(nbits), .cts_n(cts_n), .rxd(rxd), .frame(frame),
    .lead(lead), .span(span), .frames(frames), .drops(drops));
  initial
  begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Polarity mirror flips on the same edge as the register, so no false drive is seen
    if (a == CTL1_OFS)
      drive_signal_polarity_sel <= d[C1_DRIVE_SIGNAL_POLARITY];
    @(posedge clk);
  endtask : reg_wr
  task automatic rd_raw(input logic [11:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_raw
  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_raw(a, d);
    chk_val({1'b0, d}, {1'b0, exp});
  endtask : reg_rd
  task automatic finish_frame(input int tgt, input int nb, input int st, input logic [8:0] ef);
    for (int i = 0; i < 4000 && frames < tgt; i++)
      @(posedge clk);
    // Let the node's drop counter settle before anyone reads it
    repeat (2) @(posedge clk);
    chk_val(frame, ef);
    chk_rng(span, (1 + nb + st) * BIT, (1 + nb + st) * BIT + 2);
    chk_val({8'h00, drv ^ drive_signal_polarity_sel}, 9'h000);
  endtask : finish_frame
  // Count k lets a back-to-back pair be awaited as one call
  task automatic send(input logic [7:0] d, input int nb, input int st, input logic [8:0] ef,
    input int k);
    int tgt;
    tgt = frames + k;
    nbits <= nb[3:0];
    reg_wr(TXD_OFS, d);
    chk_val({8'h00, drv ^ drive_signal_polarity_sel}, 9'h001);
    finish_frame(tgt, nb, st, ef);
  endtask : send
  ////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_val({8'h00, drv}, 9'h000);
    reg_rd(CTL1_OFS, 8'h00);
    reg_wr(CTL1_OFS, 8'hFF);
    reg_rd(CTL1_OFS, 8'hFF);
    reg_rd(12'hF4F, 8'h00);
    reg_wr(CTL1_OFS, 8'h10);
    reg_wr(CTL0_OFS, 8'h80);
    send(8'hA5, 8, 1, 9'h0A5, 1);
    chk_rng(lead, BIT, 2 * BIT);
    reg_wr(CTL1_OFS, 8'h58);
    chk_val({8'h00, drv}, 9'h001);
    reg_wr(CTL0_OFS, 8'h82);
    send(8'h3C, 9, 2, 9'h13C, 1);
    chk_rng(lead, BIT, 2 * BIT);
    reg_wr(CTL1_OFS, 8'h00);
    reg_wr(CTL0_OFS, 8'hA0);
    // Pause is raised while idle, so the held character must not start
    hold_off <= 1'b1;
    nbits <= 4'h8;
    n0 = frames;
    reg_wr(TXD_OFS, 8'h96);
    repeat (100) @(posedge clk);
    chk_rng(frames, n0, n0);
    chk_val({8'h00, txd}, 9'h001);
    hold_off <= 1'b0;
    repeat (BIT * 4) @(posedge clk);
    hold_off <= 1'b1;
    finish_frame(n0 + 1, 8, 1, 9'h096);
    reg_wr(CTL0_OFS, 8'h80);
    send(8'h5A, 8, 1, 9'h05A, 1);
    hold_off <= 1'b0;
    n0 = drops;
    reg_wr(TXD_OFS, 8'hC3);
    repeat (BIT * 3) @(posedge clk);
    send(8'h7E, 8, 1, 9'h07E, 2);
    chk_rng(drops, n0 + 1, n0 + 1);
    // Even parity with nine-bit mode off: the extra bit makes the count of ones even
    reg_wr(CTL0_OFS, 8'h90);
    send(8'hA7, 9, 1, 9'h1A7, 1);
    // Loopback last: the line stays high, so the node stops capturing
    reg_wr(ADDR_OFS, 8'h3C);
    reg_wr(CTL0_OFS, 8'hC1);
    for (int m = 0; m < 4; m++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        reg_wr(CTL1_OFS, {m[1], 1'b1, m[0], ~k[0], 4'h0});
        reg_wr(TXD_OFS, rx_byte[k]);
        repeat (BIT * 14) @(posedge clk);
        chk_val({8'h00, rx_irq}, {8'h00, irq_tab[m][k]});
        rd_raw(STAT_OFS, rv);
        if (k == 1 && m >= 2)
          chk_val({8'h00, rv[ST_FRAME_START_FLAG]}, 9'h001);
        rd_raw(RXD_OFS, rv);
        if (irq_tab[m][k])
          chk_val({1'b0, rv}, {1'b0, rx_byte[k]});
        chk_val({8'h00, rx_irq}, 9'h000);
      end
    end
    end_of_test();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : ufn_port_tb
